// ==== design/eoc_map.vh ====
// Register map, field positions and codes for the external output compute block
// Operation
// - Above mode: high while value exceeds level
// - Below mode: high while value under level
// - Inside mode: high between lower and upper
// - Outside mode: high outside lower and upper
// - Hysteresis offsets the switching thresholds
// - Hysteresis symmetric: Above mode on past T+H, off past T-H
// - Low-to-high waits the turn-on delay
// - High-to-low waits the turn-off delay
// - High state lasts at least minimum high time
// - Low state lasts at least minimum low time
// - Relay sends zero low, 65535 high
// - Source alarm applies selected relay reaction
// - Active relay with mode disabled sends zero
// - Linear input clamped to input limits
// - Linear result clamped to output limits
// - Input range maps linearly onto output range
// - Source alarm sends configured alarm value
// - Undefined source or zero limits sends zero
`ifndef EOC_MAP_VH
`define EOC_MAP_VH
`define EOC_A_CTRL 6'h00
`define EOC_A_LEVEL 6'h04
`define EOC_A_HYST 6'h08
`define EOC_A_ON_DLY 6'h0c
`define EOC_A_OFF_DLY 6'h10
`define EOC_A_MIN_ON 6'h14
`define EOC_A_MIN_OFF 6'h18
`define EOC_A_ALM_DLY 6'h1c
`define EOC_A_IN_LIM 6'h20
`define EOC_A_OUT_LIM 6'h24
`define EOC_A_ALM_VAL 6'h28
`define EOC_A_STATUS 6'h2c
`define EOC_F_ACTIVE 0
`define EOC_F_LINEAR 1
`define EOC_F_MODE 4:2
`define EOC_F_ALM 7:5
`define EOC_CTRL_W 8
`define EOC_CTRL_RST 8'h00
`define EOC_MODE_DIS 3'h0
`define EOC_MODE_ABOVE 3'h1
`define EOC_MODE_BELOW 3'h2
`define EOC_MODE_INSIDE 3'h3
`define EOC_MODE_OUTSIDE 3'h4
`define EOC_ALM_KEEP 3'h0
`define EOC_ALM_IMM_OFF 3'h1
`define EOC_ALM_IMM_ON 3'h2
`define EOC_ALM_TIM_OFF 3'h3
`define EOC_ALM_TIM_ON 3'h4
`define EOC_FULL_SCALE 16'hffff
`define EOC_ZERO16 16'h0000
`define EOC_RESP_OKAY 2'h0
`define EOC_RESP_SLVERR 2'h2
`endif

// ==== design/eoc_relay.v ====
// Relay-type comparator with hysteresis, switch delays, minimum times and alarm reaction
`timescale 1ns/10ps
`include "eoc_map.vh"
module eoc_relay (
   input wire ref_clk,
   input wire nrst,
   input wire tick, // Measurement cycle pulse
   input wire signed [15:0] value, // Source value
   input wire alarm, // Source in error or range alarm
   input wire [2:0] mode, // Comparator mode
   input wire [2:0] alm_mode, // Alarm reaction
   input wire signed [15:0] lvl_lo, // Level or lower bound
   input wire signed [15:0] lvl_hi, // Upper bound
   input wire [15:0] hyst, // Hysteresis offset
   input wire [15:0] on_dly, // Turn-on delay, cycles
   input wire [15:0] off_dly, // Turn-off delay, cycles
   input wire [15:0] min_on, // Minimum high time, cycles
   input wire [15:0] min_off, // Minimum low time, cycles
   input wire [15:0] alm_dly, // Alarm force delay, cycles
   output reg state_r // Relay state
);
   reg req_r; // Comparator request, holds inside band
   reg req_nxt;
   reg [15:0] dly_r; // Cycles the request has differed
   reg [15:0] held_r; // Cycles since last change
   reg [15:0] alm_cnt_r; // Cycles in alarm
   wire signed [17:0] v = value;
   wire signed [17:0] h = {2'b00, hyst};
   wire signed [17:0] lo_dn = lvl_lo - h; // Thresholds widened to avoid wrap
   wire signed [17:0] lo_up = lvl_lo + h;
   wire signed [17:0] hi_dn = lvl_hi - h;
   wire signed [17:0] hi_up = lvl_hi + h;
   wire [15:0] need_dly = req_r ? on_dly : off_dly;
   wire [15:0] need_min = state_r ? min_on : min_off;
   wire forced = (alm_mode == `EOC_ALM_IMM_OFF) || (alm_mode == `EOC_ALM_IMM_ON) ||
      (alm_cnt_r >= alm_dly);
   wire force_val = (alm_mode == `EOC_ALM_IMM_ON) || (alm_mode == `EOC_ALM_TIM_ON);

   // Comparator with symmetric hysteresis band
   always @* begin
      req_nxt = req_r;
      case (mode)
         `EOC_MODE_ABOVE: begin
            if (v > lo_up) req_nxt = 1'b1;
            else if (v < lo_dn) req_nxt = 1'b0;
         end
         `EOC_MODE_BELOW: begin
            if (v < lo_dn) req_nxt = 1'b1;
            else if (v > lo_up) req_nxt = 1'b0;
         end
         `EOC_MODE_INSIDE: begin
            if (v > lo_up && v < hi_dn) req_nxt = 1'b1;
            else if (v < lo_dn || v > hi_up) req_nxt = 1'b0;
         end
         `EOC_MODE_OUTSIDE: begin
            if (v < lo_dn || v > hi_up) req_nxt = 1'b1;
            else if (v > lo_up && v < hi_dn) req_nxt = 1'b0;
         end
         default: req_nxt = 1'b0;
      endcase
   end

   // Output timing, evaluated once per measurement cycle
   always @(posedge ref_clk) begin
      if (!nrst) begin
         req_r <= 1'b0;
         state_r <= 1'b0;
         dly_r <= 16'h0000;
         held_r <= 16'h0000;
         alm_cnt_r <= 16'h0000;
      end else if (tick) begin
         req_r <= req_nxt;
         if (held_r != 16'hffff) held_r <= held_r + 16'h0001;
         if (alarm) begin
            // Timed reactions count first, keep-state reaction freezes the output
            if (alm_cnt_r != 16'hffff) alm_cnt_r <= alm_cnt_r + 16'h0001;
            dly_r <= 16'h0000;
            if (alm_mode != `EOC_ALM_KEEP && forced && state_r != force_val) begin
               state_r <= force_val;
               held_r <= 16'h0000;
            end
         end else begin
            alm_cnt_r <= 16'h0000;
            if (mode == `EOC_MODE_DIS) begin
               state_r <= 1'b0;
               dly_r <= 16'h0000;
            end else if (req_r != state_r) begin
               // Delay and minimum time both gate the switch
               if (dly_r >= need_dly && held_r >= need_min) begin
                  state_r <= req_r;
                  held_r <= 16'h0000;
                  dly_r <= 16'h0000;
               end else if (dly_r != 16'hffff) begin
                  dly_r <= dly_r + 16'h0001;
               end
            end else begin
               dly_r <= 16'h0000;
            end
         end
      end
   end
endmodule

// ==== design/eoc_top.v ====
// External output value computation with AXI4-Lite configuration slave
`timescale 1ns/10ps
`include "eoc_map.vh"
// Block overview
// Each measurement tick the block works out one word for a remote
// register. In relay control the word is zero or full scale, decided by
// a comparator with hysteresis, switch delays and minimum state times.
// In linear control the source is clamped, scaled between the input and
// output limits and clamped again; an alarm on the source replaces the
// result with a fixed alarm word. The word and a one-cycle pulse go to
// the link master, which frames and sends them; this block knows nothing
// of the link itself.
// Software sets everything through a small AXI4-Lite register slave.
module eoc_top (
   // Single clock; every relay time is counted in measurement ticks
   input wire ref_clk,
   // Synchronous reset, active low, clears every register
   input wire nrst,
   input wire meas_tick,
   // Source channel value, its defined flag and the three flags any of which means alarm
   input wire signed [15:0] src_value,
   input wire src_defined,
   input wire src_error,
   input wire source_overrange_flag,
   input wire source_underrange_flag,
   // Word for the remote register; the pulse tells the link master to send it
   output reg [15:0] out_value_r,
   output reg out_valid_r,
   output wire relay_state,
   // Configuration slave, write address, data and response
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // Configuration slave, read address and data
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // Configuration registers
   // All of them reset to zero, so after reset the output is inactive and
   // the block sends zero until software sets the active bit
   reg [`EOC_CTRL_W-1:0] ctrl_r;
   reg [31:0] level_r; // Lower/level in low half, upper in high half
   reg [15:0] hyst_r;
   reg [15:0] on_dly_r;
   reg [15:0] off_dly_r;
   reg [15:0] min_on_r;
   reg [15:0] min_off_r;
   reg [15:0] alm_dly_r;
   reg [31:0] in_lim_r; // Input lower/upper, signed
   reg [31:0] out_lim_r; // Output lower/upper, unsigned
   reg [15:0] alm_val_r;

   // Write channel holding state
   // Address and data may arrive in either order; each is parked here
   // until its partner turns up, so neither channel has to wait for the other
   reg aw_held_r;
   reg w_held_r;
   reg [5:0] waddr_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;
   reg tick_d_r; // Measurement tick delayed one cycle

   // Control word fields; any of the three source flags counts as alarm
   wire active = ctrl_r[`EOC_F_ACTIVE];
   wire linear = ctrl_r[`EOC_F_LINEAR];
   wire [2:0] mode = ctrl_r[`EOC_F_MODE];
   wire alarm = src_error | source_overrange_flag | source_underrange_flag;

   // A write is accepted once both address and data are held
   // Readies drop while a response is pending, which keeps at most one
   // write in flight and avoids needing a response queue
   wire wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   // Byte-lane merge of a write into an old register value
   // Lanes above a register's width are dropped when the result is stored,
   // so those bits always read back as zero
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   // Merged candidates for every writable register, picked by the decode
   wire [31:0] wm_ctrl = merge({24'h000000, ctrl_r}, wdata_r, wstrb_r);
   wire [31:0] wm_lvl = merge(level_r, wdata_r, wstrb_r);
   wire [31:0] wm_hyst = merge({16'h0000, hyst_r}, wdata_r, wstrb_r);
   wire [31:0] wm_on = merge({16'h0000, on_dly_r}, wdata_r, wstrb_r);
   wire [31:0] wm_off = merge({16'h0000, off_dly_r}, wdata_r, wstrb_r);
   wire [31:0] wm_mon = merge({16'h0000, min_on_r}, wdata_r, wstrb_r);
   wire [31:0] wm_moff = merge({16'h0000, min_off_r}, wdata_r, wstrb_r);
   wire [31:0] wm_adly = merge({16'h0000, alm_dly_r}, wdata_r, wstrb_r);
   wire [31:0] wm_inl = merge(in_lim_r, wdata_r, wstrb_r);
   wire [31:0] wm_outl = merge(out_lim_r, wdata_r, wstrb_r);
   wire [31:0] wm_aval = merge({16'h0000, alm_val_r}, wdata_r, wstrb_r);

   // Write address decode; status is read only, so writes to it are refused
   // A refused write still completes the handshake so the master never hangs
   wire wr_hit = (waddr_r == `EOC_A_CTRL) || (waddr_r == `EOC_A_LEVEL) ||
      (waddr_r == `EOC_A_HYST) || (waddr_r == `EOC_A_ON_DLY) ||
      (waddr_r == `EOC_A_OFF_DLY) || (waddr_r == `EOC_A_MIN_ON) ||
      (waddr_r == `EOC_A_MIN_OFF) || (waddr_r == `EOC_A_ALM_DLY) ||
      (waddr_r == `EOC_A_IN_LIM) || (waddr_r == `EOC_A_OUT_LIM) ||
      (waddr_r == `EOC_A_ALM_VAL);

   // Write channel capture, register update and response
   // The register changes at the same edge that raises the response, so a
   // read issued after the response always sees the new value
   always @(posedge ref_clk) begin
      if (!nrst) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         waddr_r <= 6'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `EOC_RESP_OKAY;
         ctrl_r <= `EOC_CTRL_RST;
         level_r <= 32'h00000000;
         hyst_r <= 16'h0000;
         on_dly_r <= 16'h0000;
         off_dly_r <= 16'h0000;
         min_on_r <= 16'h0000;
         min_off_r <= 16'h0000;
         alm_dly_r <= 16'h0000;
         in_lim_r <= 32'h00000000;
         out_lim_r <= 32'h00000000;
         alm_val_r <= 16'h0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            waddr_r <= {s_axi_awaddr[5:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         // Response leaves once the master has taken it
         if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
         // Both halves present: store, answer and free the channels
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `EOC_RESP_OKAY : `EOC_RESP_SLVERR;
            case (waddr_r)
               `EOC_A_CTRL: ctrl_r <= wm_ctrl[`EOC_CTRL_W-1:0];
               `EOC_A_LEVEL: level_r <= wm_lvl;
               `EOC_A_HYST: hyst_r <= wm_hyst[15:0];
               `EOC_A_ON_DLY: on_dly_r <= wm_on[15:0];
               `EOC_A_OFF_DLY: off_dly_r <= wm_off[15:0];
               `EOC_A_MIN_ON: min_on_r <= wm_mon[15:0];
               `EOC_A_MIN_OFF: min_off_r <= wm_moff[15:0];
               `EOC_A_ALM_DLY: alm_dly_r <= wm_adly[15:0];
               `EOC_A_IN_LIM: in_lim_r <= wm_inl;
               `EOC_A_OUT_LIM: out_lim_r <= wm_outl;
               `EOC_A_ALM_VAL: alm_val_r <= wm_aval[15:0];
               default: ; // Unmapped or read only, answered with error
            endcase
         end
      end
   end

   // Read decode, unmapped reads return zero with an error answer
   // Decode is combinational on the address; the word is captured at the
   // handshake edge, so later register changes do not disturb a pending answer
   reg [31:0] rd_data;
   reg rd_hit;
   always @* begin
      rd_hit = 1'b1;
      case ({s_axi_araddr[5:2], 2'b00})
         `EOC_A_CTRL: rd_data = {24'h000000, ctrl_r};
         `EOC_A_LEVEL: rd_data = level_r;
         `EOC_A_HYST: rd_data = {16'h0000, hyst_r};
         `EOC_A_ON_DLY: rd_data = {16'h0000, on_dly_r};
         `EOC_A_OFF_DLY: rd_data = {16'h0000, off_dly_r};
         `EOC_A_MIN_ON: rd_data = {16'h0000, min_on_r};
         `EOC_A_MIN_OFF: rd_data = {16'h0000, min_off_r};
         `EOC_A_ALM_DLY: rd_data = {16'h0000, alm_dly_r};
         `EOC_A_IN_LIM: rd_data = in_lim_r;
         `EOC_A_OUT_LIM: rd_data = out_lim_r;
         `EOC_A_ALM_VAL: rd_data = {16'h0000, alm_val_r};
         `EOC_A_STATUS: rd_data = {14'h0000, alarm, relay_state, out_value_r};
         default: begin
            rd_data = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Read answer held until the master takes it
   // Address is refused while an answer waits, giving one read in flight
   // and a fixed one-cycle latency from address to data
   always @(posedge ref_clk) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `EOC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_hit ? `EOC_RESP_OKAY : `EOC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Relay comparator and timing
   // The relay runs even in linear or inactive mode; its state is simply
   // not selected there, and disabled mode holds it low while no alarm is present
   eoc_relay u_relay (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .tick(meas_tick),
      .value(src_value),
      .alarm(alarm),
      .mode(mode),
      .alm_mode(ctrl_r[`EOC_F_ALM]),
      .lvl_lo(level_r[15:0]),
      .lvl_hi(level_r[31:16]),
      .hyst(hyst_r),
      .on_dly(on_dly_r),
      .off_dly(off_dly_r),
      .min_on(min_on_r),
      .min_off(min_off_r),
      .alm_dly(alm_dly_r),
      .state_r(relay_state)
   );

   // Linear scaling; one divider kept combinational since it runs once per cycle
   // Limits live in two halves of one word each: lower in the low half.
   // Input limits are signed like the source, output limits are unsigned.
   // Widths are chosen so the product and quotient cannot overflow.
   // A zero input span would divide by zero, so it yields the lower output unless the output range descends.
   // Truncation is toward zero; a descending output range never scales, as the clamp pins
   // every result to the lower output, or to the upper one where the quotient is zero.
   wire signed [16:0] in_lo = {in_lim_r[15], in_lim_r[15:0]};
   wire signed [16:0] in_hi = {in_lim_r[31], in_lim_r[31:16]};
   wire signed [16:0] o_lo = {1'b0, out_lim_r[15:0]};
   wire signed [16:0] o_hi = {1'b0, out_lim_r[31:16]};
   wire signed [16:0] x_raw = {src_value[15], src_value};
   // Clamp source to input limits
   wire signed [16:0] x_cl = (x_raw < in_lo) ? in_lo : (x_raw > in_hi) ? in_hi : x_raw;
   // Span products are formed wide before the single division
   wire signed [33:0] num = (x_cl - in_lo) * (o_hi - o_lo);
   wire signed [17:0] den = in_hi - in_lo;
   wire signed [33:0] quo = (den == 18'sd0) ? 34'sd0 : num / den;
   wire signed [33:0] y_raw = quo + o_lo;
   // Clamp result to output limits
   wire signed [33:0] y_cl = (y_raw < o_lo) ? o_lo : (y_raw > o_hi) ? o_hi : y_raw;
   // All four limits zero means the output was never set up
   wire lim_zero = (in_lim_r == 32'h00000000) && (out_lim_r == 32'h00000000);

   // Value selection for the slave register
   // Priority: inactive, then undefined source or empty limits, then alarm,
   // then the scaled word; relay control sends zero or full scale only
   reg [15:0] val_nxt;
   always @* begin
      if (!active) val_nxt = `EOC_ZERO16;
      else if (linear) begin
         if (!src_defined || lim_zero) val_nxt = `EOC_ZERO16;
         else if (alarm) val_nxt = alm_val_r;
         else val_nxt = y_cl[15:0];
      end else if (mode == `EOC_MODE_DIS) val_nxt = `EOC_ZERO16;
      else val_nxt = relay_state ? `EOC_FULL_SCALE : `EOC_ZERO16;
   end

   // Relay settles on the tick, value is latched one cycle later
   // The extra cycle lets the relay state from this tick reach the word,
   // at the cost of two cycles of latency from tick to pulse
   always @(posedge ref_clk) begin
      if (!nrst) begin
         tick_d_r <= 1'b0;
         out_value_r <= `EOC_ZERO16;
         out_valid_r <= 1'b0;
      end else begin
         tick_d_r <= meas_tick;
         out_valid_r <= tick_d_r;
         if (tick_d_r) out_value_r <= val_nxt;
      end
   end
endmodule

// ==== verification/eoc_monitor.sv ====
// Port-level checker for the external output compute block
`timescale 1ns/10ps
module eoc_monitor (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic meas_tick,
   input wire logic [15:0] out_value_r,
   input wire logic out_valid_r,
   input wire logic relay_state,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   // One domain, so one clock and one reset for all
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   tick_answer_a: assert property (meas_tick |-> ##2 out_valid_r)
      else $error("no output pulse two cycles after tick");
   valid_cause_a: assert property (out_valid_r |-> $past(meas_tick, 2))
      else $error("output pulse without tick");
   value_hold_a: assert property (!out_valid_r |-> $stable(out_value_r))
      else $error("output value moved without pulse");
   relay_rise_a: assert property ($rose(relay_state) |-> $past(meas_tick))
      else $error("relay rose outside a tick");
   relay_fall_a: assert property ($fell(relay_state) |-> $past(meas_tick))
      else $error("relay fell outside a tick");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered next cycle");
endmodule

// ==== verification/eoc_slave_model.sv ====
// Remote register device that receives each computed output word
`timescale 1ns/10ps
module eoc_slave_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic wr_strobe,
   input wire logic [15:0] wr_value,
   output logic [15:0] hold_r
);
   // Holding register takes one word per measurement cycle
   always @(posedge ref_clk) begin
      if (!nrst) begin
         hold_r <= 16'h0000;
      end else if (wr_strobe) begin
         hold_r <= wr_value;
      end
   end
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the external output compute block
`timescale 1ns/10ps
`include "eoc_map.vh"
typedef struct {logic [15:0] x; logic [3:0] f; logic [15:0] e;} eoc_row_t;
module testbench;
   logic ref_clk = 0, nrst = 0, meas_tick = 0;
   logic [15:0] src_value = 16'h0000;
   logic src_defined = 1, src_error = 0, ovr = 0, und = 0;
   logic [15:0] out_value_r, hold;
   logic out_valid_r, relay_state;
   logic [5:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, rd;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   int n_mismatch = 0, check_count = 0;
   // Rows: input, flags {defined,error,over,under}, expected word
   eoc_row_t rows[10] = '{
      '{16'h01f4, 4'h8, 16'h2ee0}, '{16'h00fa, 4'h8, 16'h1f40},
      '{16'h0000, 4'h8, 16'h0fa0}, '{16'h03e8, 4'h8, 16'h4e20},
      '{16'hffce, 4'h8, 16'h0fa0}, '{16'h07d0, 4'h8, 16'h4e20},
      '{16'h01f4, 4'hc, 16'h04d2}, '{16'h01f4, 4'ha, 16'h04d2},
      '{16'h01f4, 4'h9, 16'h04d2}, '{16'h01f4, 4'h0, 16'h0000}};
   // Expected relay state per mode for values 150, 50, 250
   logic [2:0] mexp[4] = '{3'b101, 3'b010, 3'b100, 3'b011};
   logic [15:0] vals[3] = '{16'h0096, 16'h0032, 16'h00fa};
   eoc_top i_dut (.ref_clk(ref_clk), .nrst(nrst), .meas_tick(meas_tick),
      .src_value(src_value), .src_defined(src_defined), .src_error(src_error),
      .source_overrange_flag(ovr), .source_underrange_flag(und),
      .out_value_r(out_value_r), .out_valid_r(out_valid_r), .relay_state(relay_state),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   eoc_slave_model i_slave (.ref_clk(ref_clk), .nrst(nrst), .wr_strobe(out_valid_r),
      .wr_value(out_value_r), .hold_r(hold));
   // Clock at 40 MHz
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Write: address and data offered together, bready held until bvalid is seen
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!bvalid);
      rs = bresp;
      bready <= 0;
   endtask
   // Read: rready held with the address, data taken at the edge rvalid is seen
   task automatic rdw(input logic [5:0] a);
      @(posedge ref_clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 0;
      end while (!rvalid);
      rd = rdata; rs = rresp;
      rready <= 0;
   endtask
   // Measurement ticks spaced five cycles apart
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge ref_clk) meas_tick <= 1;
         @(posedge ref_clk) meas_tick <= 0;
         repeat (3) @(posedge ref_clk);
      end
   endtask
   task automatic relay(input logic [2:0] m, input logic [2:0] al);
      wr(`EOC_A_CTRL, {24'h0, al, m, 2'b01});
   endtask
   task automatic step(input logic [15:0] v, input int n, input logic on);
      src_value <= v;
      ticks(n);
      chk("relay word", on ? 32'hffff : 32'h0, {16'h0, hold});
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Watchdog for a hung handshake
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      give_verdict;
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      nrst <= 1;
      rdw(`EOC_A_LEVEL);
      chk("level reset", 32'h0, rd);
      wr(`EOC_A_IN_LIM, 32'h03e8_0000);
      wr(`EOC_A_OUT_LIM, 32'h4e20_0fa0);
      wr(`EOC_A_ALM_VAL, 32'h04d2);
      wr(`EOC_A_CTRL, 32'h03);
      foreach (rows[i]) begin
         {src_defined, src_error, ovr, und} <= rows[i].f;
         src_value <= rows[i].x;
         ticks(1);
         chk("linear word", {16'h0, rows[i].e}, {16'h0, hold});
      end
      $display("test linear done");
      src_defined <= 1; src_error <= 0; ovr <= 0; und <= 0;
      wr(`EOC_A_LEVEL, 32'h00c8_0064);
      for (int m = 0; m < 4; m++) begin
         relay(3'(m + 1), `EOC_ALM_KEEP);
         for (int j = 0; j < 3; j++) step(vals[j], 3, mexp[m][2 - j]);
      end
      relay(`EOC_MODE_DIS, `EOC_ALM_KEEP);
      step(16'h00fa, 2, 0);
      $display("test modes done");
      relay(`EOC_MODE_ABOVE, `EOC_ALM_KEEP);
      wr(`EOC_A_HYST, 32'h000a);
      step(16'h0073, 3, 1);
      step(16'h005f, 3, 1);
      step(16'h0059, 3, 0);
      step(16'h0069, 3, 0);
      $display("test hysteresis done");
      wr(`EOC_A_HYST, 32'h0);
      wr(`EOC_A_ON_DLY, 32'h3);
      wr(`EOC_A_MIN_ON, 32'h6);
      step(16'h0096, 2, 0);
      step(16'h0096, 6, 1);
      step(16'h0032, 2, 1);
      step(16'h0032, 8, 0);
      $display("test timing done");
      step(16'h0096, 10, 1);
      src_error <= 1;
      relay(`EOC_MODE_ABOVE, `EOC_ALM_IMM_OFF);
      step(16'h0096, 1, 0);
      relay(`EOC_MODE_ABOVE, `EOC_ALM_KEEP);
      step(16'h0096, 3, 0);
      relay(`EOC_MODE_ABOVE, `EOC_ALM_IMM_ON);
      step(16'h0032, 1, 1);
      src_error <= 0;
      step(16'h0096, 1, 1);
      src_error <= 1;
      wr(`EOC_A_ALM_DLY, 32'h4);
      relay(`EOC_MODE_ABOVE, `EOC_ALM_TIM_OFF);
      step(16'h0096, 1, 1);
      step(16'h0096, 6, 0);
      relay(`EOC_MODE_ABOVE, `EOC_ALM_TIM_ON);
      step(16'h0032, 8, 1);
      src_error <= 0;
      $display("test alarm done");
      wr(`EOC_A_STATUS, 32'h1);
      chk("status write resp", 32'h2, {30'h0, rs});
      rdw(6'h30);
      chk("unmapped read resp", 32'h2, {30'h0, rs});
      chk("unmapped read data", 32'h0, rd);
      rdw(`EOC_A_LEVEL);
      chk("level readback", 32'h00c8_0064, rd);
      rdw(`EOC_A_STATUS);
      chk("status word", 32'h0001_ffff, rd);
      $display("test registers done");
      @(posedge ref_clk) nrst <= 0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1;
      rdw(`EOC_A_CTRL);
      chk("ctrl after reset", 32'h0, rd);
      chk("word after reset", 32'h0, {16'h0, out_value_r});
      $display("test reset done");
      give_verdict;
   end
endmodule
bind eoc_top eoc_monitor i_mon (.ref_clk(ref_clk), .nrst(nrst), .meas_tick(meas_tick),
   .out_value_r(out_value_r), .out_valid_r(out_valid_r), .relay_state(relay_state),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
